//--- lfm_pkg.sv
// Purpose: constants for the flash monitor register pair
// Assumes: 8-bit registers at byte offsets 0x06 and 0x07
// Notes: reset values follow the per-bit defaults of each register
package lfm_pkg;
  localparam logic [7:0] ADDR_THERM_VOUT = 8'h06;
  localparam logic [7:0] ADDR_DROOP_REV = 8'h07;
  localparam int BIT_TEMP_EN = 7;
  localparam int BIT_OVERTEMP = 6;
  localparam int BIT_WARN = 5;
  localparam int BIT_HEADROOM = 4;
  localparam int BIT_DROOP_EN = 7;
  localparam int BIT_UNUSED = 3;
  localparam logic [3:0] VOUT_CODE_RST = 4'h9;
  localparam logic [2:0] DROOP_SEL_RST = 3'h4;
  localparam logic [2:0] REVISION_DEFAULT = 3'h6; // arbitrary value
  // target voltage and droop threshold in mV: base plus step per code
  localparam int VOUT_BASE_MV = 3825;
  localparam int VOUT_STEP_MV = 125;
  localparam int DROOP_BASE_MV = 50;
  localparam int DROOP_STEP_MV = 25;
  typedef enum logic [1:0] {
    LFM_RUN = 2'b00,
    LFM_SHUTDOWN = 2'b01
  } lfm_state_e;
endpackage

//--- lfm_regs.sv
// Purpose: LED thermal, output voltage and droop monitor registers
// Assumes: host access as a simple per-cycle read/write port, comparators external
// Notes: one state struct, registered once per clock
// Notes: read data is registered, so it follows the address of the previous edge
// Notes: sensor events win over a same-cycle host clear or read-clear
`timescale 1ns/1ps
`default_nettype none
module lfm_regs #(
  parameter logic [2:0] REVISION = lfm_pkg::REVISION_DEFAULT
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ts_below_hot,
  input wire logic ts_below_warn,
  input wire logic strobe_end,
  input wire logic headroom_sufficient,
  input wire logic [3:0] selfcal_code,
  output logic temp_monitor_enable,
  output logic droop_monitor_enable,
  output logic [2:0] droop_threshold_select,
  output logic [3:0] output_voltage_code,
  output logic [12:0] target_vout_mv,
  output logic [7:0] droop_threshold_mv,
  output logic shutdown
);
  typedef struct packed {
    logic temp_en;
    logic overtemp;
    logic warn;
    logic headroom;
    logic [3:0] vout_code;
    logic droop_en;
    logic [2:0] droop_sel;
    logic [7:0] rdata;
    lfm_pkg::lfm_state_e state;
  } lfm_state_s;

  lfm_state_s st_r;
  lfm_state_s st_nxt;

  function automatic logic [12:0] vout_mv(input logic [3:0] code);
    vout_mv = 13'(lfm_pkg::VOUT_BASE_MV + int'(code) * lfm_pkg::VOUT_STEP_MV);
  endfunction

  function automatic logic [7:0] droop_mv(input logic [2:0] code);
    droop_mv = 8'(lfm_pkg::DROOP_BASE_MV + int'(code) * lfm_pkg::DROOP_STEP_MV);
  endfunction

  // the millivolt ports must hold the top code of each map without wrapping
  localparam int VOUT_TOP_MV = lfm_pkg::VOUT_BASE_MV
                               + (2 ** $bits(output_voltage_code) - 1) * lfm_pkg::VOUT_STEP_MV;
  localparam int DROOP_TOP_MV = lfm_pkg::DROOP_BASE_MV
                                + (2 ** $bits(droop_threshold_select) - 1) * lfm_pkg::DROOP_STEP_MV;

  if (VOUT_TOP_MV >= 2 ** $bits(target_vout_mv))
  begin : g_vout_fits
    $error("target voltage map does not fit its port");
  end
  if (DROOP_TOP_MV >= 2 ** $bits(droop_threshold_mv))
  begin : g_droop_fits
    $error("droop threshold map does not fit its port");
  end

  // address decode, shared by the write, read and read-clear paths
  logic sel_a;
  logic sel_b;
  logic wr_ctl;
  logic wr_droop;
  logic rd_ctl;
  logic hot_clear;
  logic hot_event;
  logic warn_event;
  logic [7:0] ctl_view;
  logic [7:0] droop_view;

  assign sel_a = (reg_addr == lfm_pkg::ADDR_THERM_VOUT);
  assign sel_b = (reg_addr == lfm_pkg::ADDR_DROOP_REV);
  assign wr_ctl = reg_wr && sel_a;
  assign wr_droop = reg_wr && sel_b;
  assign rd_ctl = reg_rd && sel_a;
  // writing a one to the overtemp bit never sets it
  assign hot_clear = wr_ctl && !reg_wdata[lfm_pkg::BIT_OVERTEMP];
  // comparators only count while monitoring is on
  assign hot_event = st_r.temp_en && ts_below_hot;
  assign warn_event = st_r.temp_en && ts_below_warn;

  // read views; the control low nibble shows calibration, not the written code, and the droop low nibble shows 0 and REVISION
  assign ctl_view = {st_r.temp_en,
                     st_r.overtemp,
                     st_r.warn,
                     st_r.headroom,
                     selfcal_code};
  assign droop_view = {st_r.droop_en,
                       st_r.droop_sel,
                       1'b0,
                       REVISION};

  always_comb
  begin
    st_nxt = st_r;
    // control register write: enable and target code
    if (wr_ctl)
    begin
      st_nxt.temp_en = reg_wdata[lfm_pkg::BIT_TEMP_EN];
      st_nxt.vout_code = reg_wdata[3:0];
    end
    // droop register write; bit 3 and the revision field are dropped
    if (wr_droop)
    begin
      st_nxt.droop_en = reg_wdata[lfm_pkg::BIT_DROOP_EN];
      st_nxt.droop_sel = reg_wdata[6:4];
    end
    // clears come first so that a same-cycle sensor event wins
    if (hot_clear)
    begin
      st_nxt.overtemp = 1'b0;
    end
    if (rd_ctl)
    begin
      st_nxt.warn = 1'b0;
    end
    if (hot_event)
    begin
      st_nxt.overtemp = 1'b1;
    end
    if (warn_event)
    begin
      st_nxt.warn = 1'b1;
    end
    // headroom is sampled only at strobe end and held otherwise
    if (strobe_end)
    begin
      st_nxt.headroom = headroom_sufficient;
    end
    // shutdown latches with the flag; only a software clear releases it
    case (st_r.state)
      lfm_pkg::LFM_RUN:
      begin
        if (st_nxt.overtemp)
        begin
          st_nxt.state = lfm_pkg::LFM_SHUTDOWN;
        end
      end
      lfm_pkg::LFM_SHUTDOWN:
      begin
        if (!st_nxt.overtemp)
        begin
          st_nxt.state = lfm_pkg::LFM_RUN;
        end
      end
      default:
      begin
        st_nxt.state = st_nxt.overtemp ? lfm_pkg::LFM_SHUTDOWN : lfm_pkg::LFM_RUN;
      end
    endcase
    // registered read data follows the address of the previous edge
    case (1'b1)
      sel_a: st_nxt.rdata = ctl_view;
      sel_b: st_nxt.rdata = droop_view;
      default: st_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '{temp_en: 1'b0, overtemp: 1'b0, warn: 1'b0, headroom: 1'b0,
                vout_code: lfm_pkg::VOUT_CODE_RST, droop_en: 1'b0,
                droop_sel: lfm_pkg::DROOP_SEL_RST, rdata: 8'h00,
                state: lfm_pkg::LFM_RUN};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign temp_monitor_enable = st_r.temp_en;
  assign droop_monitor_enable = st_r.droop_en;
  assign droop_threshold_select = st_r.droop_sel;
  assign output_voltage_code = st_r.vout_code;
  assign target_vout_mv = vout_mv(st_r.vout_code);
  assign droop_threshold_mv = droop_mv(st_r.droop_sel);
  assign shutdown = (st_r.state == lfm_pkg::LFM_SHUTDOWN);
endmodule
`default_nettype wire

//--- lfm_regs_assertions.sv
// Purpose: port checks of lfm_regs
// Assumes: default revision value
// Notes: rdata shows the address of one edge back
`timescale 1ns/1ps
`default_nettype none
module lfm_chk (
  input wire logic mclk, resetn, reg_wr, temp_monitor_enable, shutdown,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, droop_threshold_mv,
  input wire logic [3:0] output_voltage_code, selfcal_code,
  input wire logic [2:0] droop_threshold_select,
  input wire logic [12:0] target_vout_mv
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic clr = reg_wr && reg_addr == 8'h06 && !reg_wdata[6];
  chk_vout_map: assert property (target_vout_mv == 13'h0ef1 + 13'h07d * output_voltage_code)
    else $error("vout map");
  chk_droop_map: assert property (droop_threshold_mv == 8'h32 + 8'h19 * droop_threshold_select)
    else $error("droop map");
  chk_ctl_write: assert property (reg_wr && reg_addr == 8'h06 |=>
    {temp_monitor_enable, output_voltage_code} == {$past(reg_wdata[7]), $past(reg_wdata[3:0])})
    else $error("ctl write");
  chk_sel_write: assert property (reg_wr && reg_addr == 8'h07 |=>
    droop_threshold_select == $past(reg_wdata[6:4])) else $error("sel write");
  chk_cal_read: assert property ($past(reg_addr) == 8'h06 |->
    reg_rdata[3:0] == $past(selfcal_code)) else $error("cal read");
  chk_rev_fixed: assert property ($past(reg_addr) == 8'h07 |->
    reg_rdata[3:0] == {1'b0, lfm_pkg::REVISION_DEFAULT}) else $error("rev read");
  chk_unmapped_zero: assert property (!($past(reg_addr) inside {8'h06, 8'h07}) |->
    reg_rdata == 8'h00) else $error("unmapped read");
  chk_shut_hold: assert property (shutdown && !clr && !$past(clr) |=> shutdown)
    else $error("shutdown hold");
  cover property (shutdown);
  cover property (clr);
  cover property (reg_wr && reg_addr == 8'h07);
endmodule
bind lfm_regs lfm_chk u_chk (.*);
`default_nettype wire

//--- lfm_host.sv
// Purpose: host model driving the register strobes
// Assumes: changes 2 ns after a rising edge
// Notes: write data inverted once taken, so stale data never helps
`timescale 1ns/1ps
`default_nettype none
module lfm_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr, reg_wdata,
  output logic reg_wr, reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk) #2 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge mclk) #2 {reg_wdata, reg_wr} = {~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk) #2 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge mclk) #2 reg_rd = 1'b0;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- led_flash_monitor_registers_test.sv
// Purpose: register sequences on lfm_regs
// Assumes: host model h drives the strobes
// Notes: selfcal held at 3 so reads differ from writes
`timescale 1ns/1ps
`default_nettype none
module led_flash_monitor_registers_test;
  logic mclk = 1'b0, resetn = 1'b0, reg_wr, reg_rd, shutdown, temp_monitor_enable;
  logic ts_below_hot = 1'b0, ts_below_warn = 1'b0, strobe_end = 1'b0, headroom_sufficient = 1'b0;
  logic droop_monitor_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, droop_threshold_mv;
  logic [3:0] selfcal_code = 4'h3, output_voltage_code;
  logic [2:0] droop_threshold_select;
  logic [12:0] target_vout_mv;
  int n_errors = 0, checks_done = 0;
  lfm_regs dut (.*);
  lfm_host h (.*);
  always #12.5 mclk = ~mclk;
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] q;
    h.rd(a, q);
    checks_done++;
    n_errors += int'(q !== e);
    if (q !== e) $display("wrong value rdata %h exp %h got %h", a, e, q);
  endtask
  task automatic ck(input string what, input logic [12:0] e, input logic [12:0] got);
    checks_done++;
    if (got !== e)
    begin
      n_errors++;
      $display("wrong value %s exp %h got %h", what, e, got);
    end
  endtask
  task give_verdict(input int bump);
    n_errors += bump;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial #20000 give_verdict(1);
  initial
  begin
    repeat (3) @(posedge mclk);
    #2 resetn = 1'b1;
    ck("shutdown", 13'h0000, 13'(shutdown));
    ck("target_vout_mv", 13'h1356, target_vout_mv);
    ck("droop_threshold_mv", 13'h0096, 13'(droop_threshold_mv));
    rc(8'h06, 8'h03);
    rc(8'h07, 8'h46);
    h.wr(8'h06, 8'h8a);
    ck("output_voltage_code", 13'h000a, 13'(output_voltage_code));
    ck("target_vout_mv", 13'h13d3, target_vout_mv);
    ck("temp_monitor_enable", 13'h0001, 13'(temp_monitor_enable));
    rc(8'h06, 8'h83);
    h.wr(8'h07, 8'hff);
    ck("droop_threshold_mv", 13'h00e1, 13'(droop_threshold_mv));
    ck("droop_threshold_select", 13'h0007, 13'(droop_threshold_select));
    ck("droop_monitor_enable", 13'h0001, 13'(droop_monitor_enable));
    rc(8'h07, 8'hf6);
    $display("config test done");
    {ts_below_warn, strobe_end, headroom_sufficient} = 3'h7;
    @(posedge mclk) #2 {ts_below_warn, strobe_end, headroom_sufficient} = 3'h0;
    rc(8'h06, 8'hb3);
    rc(8'h06, 8'h93);
    ts_below_hot = 1'b1;
    @(posedge mclk) #2 ts_below_hot = 1'b0;
    rc(8'h06, 8'hd3);
    ck("shutdown", 13'h0001, 13'(shutdown));
    h.wr(8'h06, 8'h8a);
    rc(8'h06, 8'h93);
    ck("shutdown", 13'h0000, 13'(shutdown));
    $display("flag test done");
    give_verdict(0);
  end
endmodule
`default_nettype wire
